/* File: instrument_status_event_bank.sv */
// status register bank: fault, activity and alarm groups
// ==========================================================
`timescale 1ns/1ns
`default_nettype none
module instrument_status_event_bank
  import status_bank_pkg::*;
#(
  parameter int COUNT_W = 20
) (
  // clock and reset
  input  wire logic               I_CLK,
  input  wire logic               I_RST,
  // instrument state
  input  wire fault_in_t          I_FAULT,
  input  wire activity_in_t       I_ACTIVITY,
  input  wire alarm_in_t          I_ALARM,
  input  wire logic [COUNT_W-1:0] I_READING_COUNT,
  input  wire logic [COUNT_W-1:0] I_READING_COUNT_THRESHOLD_SETTING,
  // commands and register access
  input  wire cmd_t               I_CMD,
  input  wire access_t            I_ACCESS,
  // answers
  output logic [15:0]             O_RDATA,
  output logic                    O_RVALID,
  output logic [2:0]              O_SUMMARY
);

  typedef struct packed {
    logic [15:0] rdata;
    logic        rvalid;
    logic [15:0] en_fault;
    logic [15:0] en_act;
    logic [15:0] en_alarm;
    logic [2:0]  summary;
    logic        cfg_front;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;

  logic [NUM_OVL-1:0] ovl_raw;
  logic [NUM_OVL-1:0] ovl_pass;
  logic [15:0]        fault_lvl;
  logic [15:0]        fault_pls;
  logic [15:0]        act_lvl;
  logic [15:0]        act_pls;
  logic [15:0]        alarm_lvl;
  logic [15:0]        alarm_pls;
  logic [15:0]        fault_cond;
  logic [15:0]        fault_evt;
  logic [15:0]        act_cond;
  logic [15:0]        act_evt;
  logic [15:0]        alarm_cond;
  logic [15:0]        alarm_evt;
  logic               clr_fault;
  logic               clr_act;
  logic               clr_alarm;
  logic               start_or_read;

  function automatic logic is_event_read(input access_t a, input logic [1:0] grp);
    is_event_read = a.rd && (a.group == grp) && (a.view == VIEW_EVENT);
  endfunction : is_event_read

  // ==========================================================
  // overload gating
  always_comb begin
    ovl_raw          = '0;
    ovl_raw[OV_VOLT] = I_FAULT.volt_ovl;
    ovl_raw[OV_CURR] = I_FAULT.curr_ovl;
    ovl_raw[OV_FREQ] = I_FAULT.freq_ovl;
    ovl_raw[OV_CAP]  = I_FAULT.cap_ovl;
    ovl_raw[OV_RES]  = I_FAULT.res_ovl;
    ovl_raw[OV_TEMP] = I_FAULT.temp_ovl;
  end

  overload_gate #(
    .N       (NUM_OVL)
  ) u_gate (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_ovl   (ovl_raw),
    .i_start (I_CMD.acquisition_start_command),
    .o_pass  (ovl_pass)
  );

  // ==========================================================
  // source mapping per group
  always_comb begin
    fault_lvl = '0;
    fault_pls = '0;
    fault_pls[FB_VOLT]   = ovl_pass[OV_VOLT];
    fault_pls[FB_CURR]   = ovl_pass[OV_CURR];
    fault_pls[FB_FREQ]   = ovl_pass[OV_FREQ];
    fault_pls[FB_CAP]    = ovl_pass[OV_CAP];
    fault_lvl[FB_CAL]    = I_FAULT.cal_corrupt;
    fault_pls[FB_RES]    = ovl_pass[OV_RES];
    fault_pls[FB_TEMP]   = ovl_pass[OV_TEMP];
    fault_lvl[FB_LOWER]  = I_FAULT.lower_limit_fail;
    fault_lvl[FB_MEMOVF] = I_FAULT.memory_overflow;

    act_lvl = '0;
    act_pls = '0;
    act_lvl[AB_CAL]      = I_ACTIVITY.calibrating;
    act_lvl[AB_SELFTEST] = I_ACTIVITY.self_test;
    act_lvl[AB_SCAN]     = I_ACTIVITY.scanning;
    act_lvl[AB_WAIT]     = I_ACTIVITY.wait_trigger;
    act_lvl[AB_DRIVE]    = I_ACTIVITY.removable_drive_present;
    act_lvl[AB_FRONTCFG] = st.cfg_front;
    act_lvl[AB_THRESH]   = I_READING_COUNT > I_READING_COUNT_THRESHOLD_SETTING;
    act_lvl[AB_LOCK]     = I_ACTIVITY.locked;
    act_pls[AB_SETCHG]   = I_ACTIVITY.front_cfg_change
                           | I_ACTIVITY.remote_cfg_change;
    act_lvl[AB_ERRQ]     = I_ACTIVITY.error_queue_nonempty;

    alarm_lvl = '0;
    alarm_pls = '0;
    alarm_pls[LB_EVT0 +: NUM_ALM] = I_ALARM.alarm_event;
    alarm_lvl[LB_QNE]             = I_ALARM.queue_nonempty;
    alarm_pls[LB_QOVF]            = I_ALARM.queue_overflow;
    alarm_lvl[LB_TRG0 +: NUM_ALM] = I_ALARM.triggered;
  end

  // reading an event view or clear-status empties the group's event view
  assign clr_fault = I_CMD.clear_status || is_event_read(I_ACCESS, GRP_FAULT);
  assign clr_act   = I_CMD.clear_status || is_event_read(I_ACCESS, GRP_ACT);
  assign clr_alarm = I_CMD.clear_status || is_event_read(I_ACCESS, GRP_ALARM);

  // ==========================================================
  // group latches
  status_event_latch #(
    .VALID   (FAULT_VALID),
    .EVONLY  (FAULT_EVONLY)
  ) u_fault (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_cond  (fault_lvl),
    .i_pulse (fault_pls),
    .i_clear (clr_fault),
    .o_cond  (fault_cond),
    .o_event (fault_evt)
  );

  status_event_latch #(
    .VALID   (ACT_VALID),
    .EVONLY  (ACT_EVONLY)
  ) u_act (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_cond  (act_lvl),
    .i_pulse (act_pls),
    .i_clear (clr_act),
    .o_cond  (act_cond),
    .o_event (act_evt)
  );

  status_event_latch #(
    .VALID   (ALARM_VALID),
    .EVONLY  (ALARM_EVONLY)
  ) u_alarm (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_cond  (alarm_lvl),
    .i_pulse (alarm_pls),
    .i_clear (clr_alarm),
    .o_cond  (alarm_cond),
    .o_event (alarm_evt)
  );

  // ==========================================================
  // access, enables and summary
  assign start_or_read = I_CMD.acquisition_start_command || I_CMD.read_measure_command;

  always_comb begin
    next_st = st;
    next_st.rvalid = I_ACCESS.rd;
    // a change in the same cycle as a start still counts as after it
    if (I_ACTIVITY.front_cfg_change) begin
      next_st.cfg_front = 1'b1;
    end else if (start_or_read) begin
      next_st.cfg_front = 1'b0;
    end
    if (I_ACCESS.wr && I_ACCESS.view == VIEW_ENABLE) begin
      if (I_ACCESS.group == GRP_FAULT) begin
        next_st.en_fault = I_ACCESS.wdata & FAULT_VALID;
      end else if (I_ACCESS.group == GRP_ACT) begin
        next_st.en_act = I_ACCESS.wdata & ACT_VALID;
      end else if (I_ACCESS.group == GRP_ALARM) begin
        next_st.en_alarm = I_ACCESS.wdata & ALARM_VALID;
      end
    end
    if (I_ACCESS.rd) begin
      // unmapped group or view answers zero
      next_st.rdata = RST_REG;
      if (I_ACCESS.group == GRP_FAULT && I_ACCESS.view == VIEW_COND) begin
        next_st.rdata = fault_cond;
      end else if (I_ACCESS.group == GRP_FAULT && I_ACCESS.view == VIEW_EVENT) begin
        next_st.rdata = fault_evt;
      end else if (I_ACCESS.group == GRP_FAULT && I_ACCESS.view == VIEW_ENABLE) begin
        next_st.rdata = st.en_fault;
      end else if (I_ACCESS.group == GRP_ACT && I_ACCESS.view == VIEW_COND) begin
        next_st.rdata = act_cond;
      end else if (I_ACCESS.group == GRP_ACT && I_ACCESS.view == VIEW_EVENT) begin
        next_st.rdata = act_evt;
      end else if (I_ACCESS.group == GRP_ACT && I_ACCESS.view == VIEW_ENABLE) begin
        next_st.rdata = st.en_act;
      end else if (I_ACCESS.group == GRP_ALARM && I_ACCESS.view == VIEW_COND) begin
        next_st.rdata = alarm_cond;
      end else if (I_ACCESS.group == GRP_ALARM && I_ACCESS.view == VIEW_EVENT) begin
        next_st.rdata = alarm_evt;
      end else if (I_ACCESS.group == GRP_ALARM && I_ACCESS.view == VIEW_ENABLE) begin
        next_st.rdata = st.en_alarm;
      end
    end
    next_st.summary[GRP_FAULT] = |(fault_evt & st.en_fault);
    next_st.summary[GRP_ACT]   = |(act_evt & st.en_act);
    next_st.summary[GRP_ALARM] = |(alarm_evt & st.en_alarm);
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st.rdata     <= RST_REG;
      st.rvalid    <= 1'b0;
      st.en_fault  <= RST_REG;
      st.en_act    <= RST_REG;
      st.en_alarm  <= RST_REG;
      st.summary   <= 3'h0;
      st.cfg_front <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA   = st.rdata;
  assign O_RVALID  = st.rvalid;
  assign O_SUMMARY = st.summary;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence volt_seen_s;
    ovl_pass[OV_VOLT] && !I_CMD.acquisition_start_command;
  endsequence
  sequence volt_silent_s;
    !ovl_pass[OV_VOLT];
  endsequence

  once_per_start_a: assert property (volt_seen_s |=> volt_silent_s)
    else $error("overload reported twice without a new start");
  volt_latch_a: assert property (ovl_pass[OV_VOLT] |=> fault_evt[FB_VOLT])
    else $error("voltage overload not latched");
  evonly_cond_a: assert property (((fault_cond & FAULT_EVONLY) == RST_REG)
                                  && ((alarm_cond & ALARM_EVONLY) == RST_REG))
    else $error("event-only bit seen in condition view");
  cal_level_a: assert property (I_FAULT.cal_corrupt |=> fault_cond[FB_CAL])
    else $error("calibration corrupt not shown");
  scan_track_a: assert property (##1 act_cond[AB_SCAN] == $past(I_ACTIVITY.scanning))
    else $error("scanning condition does not track");
  front_cfg_a: assert property (I_ACTIVITY.front_cfg_change |=> ##1 act_cond[AB_FRONTCFG])
    else $error("front panel change not held");
  event_hold_a: assert property (fault_evt[FB_CAL] && !clr_fault |=> fault_evt[FB_CAL])
    else $error("event bit dropped without clear");
  read_clear_a: assert property (clr_alarm && !alarm_pls[LB_QOVF] |=> !alarm_evt[LB_QOVF])
    else $error("event bit survived clear");
  summary_en_a: assert property (##1 O_SUMMARY[GRP_ACT] == $past(|(act_evt & st.en_act)))
    else $error("activity summary wrong");
  rsv_zero_a: assert property (O_RVALID
                               |-> ((O_RDATA & ~(FAULT_VALID | ACT_VALID | ALARM_VALID))
                                    == RST_REG))
    else $error("reserved bits read nonzero");
  rise_event_a: assert property ($rose(fault_cond[FB_CAL]) |-> fault_evt[FB_CAL])
    else $error("condition rise did not set event");
  queue_ne_a: assert property (I_ALARM.queue_nonempty |=> alarm_cond[LB_QNE])
    else $error("alarm queue state missing");

endmodule : instrument_status_event_bank
`default_nettype wire

/* File: instrument_status_event_bank_test.sv */
// self-checking bench for the instrument status register bank
`timescale 1ns/1ns
`default_nettype none
module instrument_status_event_bank_test
  import status_bank_pkg::*;
;
  logic         clk;
  logic         rst;
  fault_in_t    fault;
  activity_in_t act;
  alarm_in_t    alm;
  logic [19:0]  count;
  logic [19:0]  thresh;
  access_t      access;
  cmd_t         cmd;
  logic [15:0]  rdata;
  logic         rvalid;
  logic [2:0]   summary;
  logic [31:0]  seed;
  int           err_count;
  int           check_count;

  localparam int          EV_GRP [12] = '{0, 0, 0, 0, 0, 0, 2, 2, 2, 2, 2, 1};
  localparam int          EV_BIT [12] = '{0, 1, 5, 7, 9, 10, 0, 1, 2, 3, 5, 11};
  localparam logic [15:0] VALIDS [3]  = '{16'h1FA3, 16'h2FB3, 16'h03FF};

  instrument_status_event_bank #(.COUNT_W(20)) dut_u (
    .I_CLK(clk), .I_RST(rst), .I_FAULT(fault), .I_ACTIVITY(act), .I_ALARM(alm),
    .I_READING_COUNT(count), .I_READING_COUNT_THRESHOLD_SETTING(thresh),
    .I_CMD(cmd), .I_ACCESS(access), .O_RDATA(rdata), .O_RVALID(rvalid),
    .O_SUMMARY(summary));

  status_host host_u (
    .i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_access(access), .o_cmd(cmd));

  initial begin
    clk = 1'b0; rst = 1'b1; fault = '0; act = '0; alm = '0;
    count = 20'h00000; thresh = 20'h00000;
    seed = 32'h00014435; err_count = 0; check_count = 0;
  end

  always #5 clk = ~clk;

  // ==========
  // helpers
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [1:0] g, input logic [1:0] v, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host_u.read_reg(g, v, d, ok);
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: answer %h expected %h", $time, 1'b0, 1'b1);
      report_and_stop();
    end else begin
      check(d, exp);
    end
  endtask : rd_chk

  // condition view as the level inputs dictate; front-panel bit stays low here
  function automatic logic [15:0] cond_exp(input int g);
    logic [15:0] c;
    c = 16'h0000;
    if (g == 0) begin
      c[8]  = fault.cal_corrupt;
      c[11] = fault.lower_limit_fail;
      c[12] = fault.memory_overflow;
    end else if (g == 1) begin
      c[1:0] = {act.self_test, act.calibrating};
      c[5:4] = {act.wait_trigger, act.scanning};
      c[7]   = act.removable_drive_present;
      c[9]   = count > thresh;
      c[10]  = act.locked;
      c[13]  = act.error_queue_nonempty;
    end else begin
      c[4]   = alm.queue_nonempty;
      c[9:6] = alm.triggered;
    end
    return c;
  endfunction : cond_exp

  // one-cycle pulse on source k; levels are kept by the masks
  task automatic pulse_src(input int k);
    @(posedge clk);
    case (k)
      0: fault.volt_ovl <= 1'b1;
      1: fault.curr_ovl <= 1'b1;
      2: fault.freq_ovl <= 1'b1;
      3: fault.cap_ovl <= 1'b1;
      4: fault.res_ovl <= 1'b1;
      5: fault.temp_ovl <= 1'b1;
      10: alm.queue_overflow <= 1'b1;
      11: act.remote_cfg_change <= 1'b1;
      12: act.front_cfg_change <= 1'b1;
      default: alm.alarm_event[k-6] <= 1'b1;
    endcase
    @(posedge clk);
    fault <= fault_in_t'(fault & 9'h007);
    act   <= activity_in_t'(act & 9'h1F3);
    alm   <= alarm_in_t'(alm & 10'h02F);
  endtask : pulse_src

  // ==========
  // main sequence
  initial begin
    int          g;
    int          k;
    logic [31:0] w;
    logic [15:0] prev [3];
    prev = '{16'h0000, 16'h0000, 16'h0000};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (g = 0; g < 9; g++) begin
      rd_chk(2'(g / 3), 2'(g % 3), 16'h0000);
    end
    for (k = 0; k < 12; k++) begin
      pulse_src(k);
      rd_chk(2'(EV_GRP[k]), VIEW_EVENT, 16'(1 << EV_BIT[k]));
      rd_chk(2'(EV_GRP[k]), VIEW_COND, 16'h0000);
      rd_chk(2'(EV_GRP[k]), VIEW_EVENT, 16'h0000);
    end
    pulse_src(0);
    rd_chk(GRP_FAULT, VIEW_EVENT, 16'h0000);
    host_u.send_cmd(cmd_t'(3'b100));
    pulse_src(0);
    rd_chk(GRP_FAULT, VIEW_EVENT, 16'h0001);
    for (k = 0; k < 2; k++) begin
      pulse_src(12);
      rd_chk(GRP_ACT, VIEW_COND, 16'h0100);
      rd_chk(GRP_ACT, VIEW_EVENT, 16'h0900);
      host_u.send_cmd(cmd_t'((k == 0) ? 3'b100 : 3'b010));
      rd_chk(GRP_ACT, VIEW_COND, 16'h0000);
    end
    // random levels; equal count and threshold forced once
    for (k = 0; k < 24; k++) begin
      w = xorshift();
      @(posedge clk);
      fault  <= fault_in_t'({6'h00, w[2:0]});
      act    <= activity_in_t'({w[8:4], 2'b00, w[10:9]});
      alm    <= alarm_in_t'({4'h0, w[11], 1'b0, w[15:12]});
      count  <= 20'(w[19:16]);
      thresh <= 20'((k == 1) ? w[19:16] : w[23:20]);
      repeat (2) @(posedge clk);
      for (g = 0; g < 3; g++) begin
        rd_chk(2'(g), VIEW_COND, cond_exp(g));
        rd_chk(2'(g), VIEW_COND, cond_exp(g));
        rd_chk(2'(g), VIEW_EVENT, cond_exp(g) & ~prev[g]);
        prev[g] = cond_exp(g);
      end
    end
    @(posedge clk);
    fault <= '0;
    act   <= '0;
    alm   <= '0;
    for (g = 0; g < 3; g++) begin
      w = xorshift();
      host_u.write_reg(2'(g), VIEW_ENABLE, w[15:0]);
      host_u.write_reg(2'(g), VIEW_COND, w[31:16]);
      rd_chk(2'(g), VIEW_ENABLE, w[15:0] & VALIDS[g]);
      rd_chk(2'(g), VIEW_COND, cond_exp(g));
    end
    host_u.write_reg(GRP_ACT, VIEW_ENABLE, 16'h0001);
    @(posedge clk);
    act.calibrating <= 1'b1;
    @(posedge clk);
    act.calibrating <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(16'(summary), 16'h0002);
    host_u.send_cmd(cmd_t'(3'b001));
    repeat (3) @(posedge clk);
    #1;
    check(16'(summary), 16'h0000);
    host_u.write_reg(GRP_ALARM, VIEW_ENABLE, 16'h0010);
    @(posedge clk);
    alm.queue_nonempty <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(16'(summary), 16'h0004);
    host_u.write_reg(2'h3, VIEW_ENABLE, 16'hFFFF);
    rd_chk(2'h3, VIEW_ENABLE, 16'h0000);
    rd_chk(GRP_FAULT, 2'h3, 16'h0000);
    report_and_stop();
  end
endmodule : instrument_status_event_bank_test
`default_nettype wire

/* File: overload_gate.sv */
// lets each overload through once per acquisition start
`timescale 1ns/1ns
`default_nettype none
module overload_gate
  import status_bank_pkg::*;
#(
  parameter int N = NUM_OVL
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // overload pulses and re-arm
  input  wire logic [N-1:0] i_ovl,
  input  wire logic         i_start,
  // gated overload pulses
  output logic      [N-1:0] o_pass
);

  typedef struct packed {
    logic [N-1:0] armed;
  } gate_state_t;

  gate_state_t st;
  gate_state_t next_st;

  // ==========================================================
  // arm logic
  always_comb begin
    next_st = st;
    if (i_start) begin
      next_st.armed = '1;
    end else begin
      next_st.armed = st.armed & ~i_ovl;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st.armed <= '1;
    end else begin
      st <= next_st;
    end
  end

  // pass in the same cycle so the event bit is not a cycle late
  assign o_pass = i_ovl & st.armed;

endmodule : overload_gate
`default_nettype wire

/* File: status_bank_pkg.sv */
// constants and carrier types shared by the status register bank
`default_nettype none
package status_bank_pkg;

  // ==========================================================
  // register geometry and access codes
  localparam int         REG_W       = 16;
  localparam int         NUM_OVL     = 6;
  localparam logic [1:0] GRP_FAULT   = 2'h0;
  localparam logic [1:0] GRP_ACT     = 2'h1;
  localparam logic [1:0] GRP_ALARM   = 2'h2;
  localparam logic [1:0] VIEW_COND   = 2'h0;
  localparam logic [1:0] VIEW_EVENT  = 2'h1;
  localparam logic [1:0] VIEW_ENABLE = 2'h2;
  localparam logic [15:0] RST_REG    = 16'h0000;

  // ==========================================================
  // measurement fault bit positions
  localparam int FB_VOLT   = 0;
  localparam int FB_CURR   = 1;
  localparam int FB_FREQ   = 5;
  localparam int FB_CAP    = 7;
  localparam int FB_CAL    = 8;
  localparam int FB_RES    = 9;
  localparam int FB_TEMP   = 10;
  localparam int FB_LOWER  = 11;
  localparam int FB_MEMOVF = 12;

  // overload gate lane order
  localparam int OV_VOLT = 0;
  localparam int OV_CURR = 1;
  localparam int OV_FREQ = 2;
  localparam int OV_CAP  = 3;
  localparam int OV_RES  = 4;
  localparam int OV_TEMP = 5;

  // ==========================================================
  // activity bit positions
  localparam int AB_CAL      = 0;
  localparam int AB_SELFTEST = 1;
  localparam int AB_SCAN     = 4;
  localparam int AB_WAIT     = 5;
  localparam int AB_DRIVE    = 7;
  localparam int AB_FRONTCFG = 8;
  localparam int AB_THRESH   = 9;
  localparam int AB_LOCK     = 10;
  localparam int AB_SETCHG   = 11;
  localparam int AB_ERRQ     = 13;

  // ==========================================================
  // alarm bit positions
  localparam int LB_EVT0 = 0;
  localparam int LB_QNE  = 4;
  localparam int LB_QOVF = 5;
  localparam int LB_TRG0 = 6;
  localparam int NUM_ALM = 4;

  // ==========================================================
  // implemented and event-only masks
  localparam logic [15:0] FAULT_VALID  = 16'h1FA3;
  localparam logic [15:0] FAULT_EVONLY = 16'h06A3;
  localparam logic [15:0] ACT_VALID    = 16'h2FB3;
  localparam logic [15:0] ACT_EVONLY   = 16'h0800;
  localparam logic [15:0] ALARM_VALID  = 16'h03FF;
  localparam logic [15:0] ALARM_EVONLY = 16'h002F;

  // ==========================================================
  // carrier structs
  typedef struct packed {
    logic volt_ovl;
    logic curr_ovl;
    logic freq_ovl;
    logic cap_ovl;
    logic res_ovl;
    logic temp_ovl;
    logic cal_corrupt;
    logic lower_limit_fail;
    logic memory_overflow;
  } fault_in_t;

  typedef struct packed {
    logic calibrating;
    logic self_test;
    logic scanning;
    logic wait_trigger;
    logic removable_drive_present;
    logic front_cfg_change;
    logic remote_cfg_change;
    logic locked;
    logic error_queue_nonempty;
  } activity_in_t;

  typedef struct packed {
    logic [3:0] alarm_event;
    logic       queue_nonempty;
    logic       queue_overflow;
    logic [3:0] triggered;
  } alarm_in_t;

  typedef struct packed {
    logic acquisition_start_command;
    logic read_measure_command;
    logic clear_status;
  } cmd_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  group;
    logic [1:0]  view;
    logic [15:0] wdata;
  } access_t;

endpackage : status_bank_pkg
`default_nettype wire

/* File: status_event_latch.sv */
// one register group: condition view and sticky event view
`timescale 1ns/1ns
`default_nettype none
module status_event_latch
  import status_bank_pkg::*;
#(
  parameter logic [15:0] VALID  = 16'hFFFF,
  parameter logic [15:0] EVONLY = 16'h0000
) (
  // condition levels, clock and reset
  input  wire logic [15:0] i_cond,
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // event sources and clear
  input  wire logic [15:0] i_pulse,
  input  wire logic        i_clear,
  // views
  output logic      [15:0] o_cond,
  output logic      [15:0] o_event
);

  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] evt;
  } latch_state_t;

  latch_state_t st;
  latch_state_t next_st;
  logic [15:0]  cond_eff;

  // ==========================================================
  // condition tracking and event latching
  always_comb begin
    next_st  = st;
    cond_eff = i_cond & VALID & ~EVONLY;
    next_st.cond = cond_eff;
    // set wins over clear so a same-cycle event survives the read
    next_st.evt = ((i_clear ? RST_REG : st.evt)
                   | (cond_eff & ~st.cond)
                   | (i_pulse & VALID));
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st.cond <= RST_REG;
      st.evt  <= RST_REG;
    end else begin
      st <= next_st;
    end
  end

  assign o_cond  = st.cond;
  assign o_event = st.evt;

endmodule : status_event_latch
`default_nettype wire

/* File: status_host.sv */
// remote host model: register reads, enable writes and status commands
`timescale 1ns/1ns
`default_nettype none
module status_host
  import status_bank_pkg::*;
(
  // clock and answers
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  // requests
  output var  access_t     o_access,
  output var  cmd_t        o_cmd
);
  initial begin
    o_access = '0;
    o_cmd    = '0;
  end

  // ==========
  // read: one taking edge, then a bounded wait for the answer
  task automatic read_reg(input logic [1:0] grp, input logic [1:0] vw,
                          output logic [15:0] data, output logic ok);
    int n;
    ok   = 1'b0;
    data = 16'h0000;
    @(posedge i_clk);
    o_access.rd    <= 1'b1;
    o_access.group <= grp;
    o_access.view  <= vw;
    @(posedge i_clk);
    o_access.rd <= 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_rvalid === 1'b1) begin
        ok   = 1'b1;
        data = i_rdata;
      end else begin
        @(posedge i_clk);
      end
    end
  endtask : read_reg

  // ==========
  // write: data inverted once released, so a stale latch shows up
  task automatic write_reg(input logic [1:0] grp, input logic [1:0] vw, input logic [15:0] d);
    @(posedge i_clk);
    o_access.wr    <= 1'b1;
    o_access.group <= grp;
    o_access.view  <= vw;
    o_access.wdata <= d;
    @(posedge i_clk);
    o_access.wr    <= 1'b0;
    o_access.wdata <= ~d;
  endtask : write_reg

  task automatic send_cmd(input cmd_t c);
    @(posedge i_clk);
    o_cmd <= c;
    @(posedge i_clk);
    o_cmd <= '0;
  endtask : send_cmd
endmodule : status_host
`default_nettype wire
